// ---- uflc_cfg.svh ----
/*
 * Constants of the flow and line control block: pin roles, mode codes,
 * bit positions, receive thresholds and timing figures.
 * Assumes a single 25 MHz clock; included by bare name.
 */
`ifndef UFLC_CFG_SVH
`define UFLC_CFG_SVH

`define UFLC_GPIO_N 6
`define UFLC_PIN_WAKE 0
`define UFLC_PIN_DSR 2
`define UFLC_PIN_DTR 3
`define UFLC_PIN_CTS 4
`define UFLC_PIN_DIR 5

`define UFLC_PMODE_RTSCTS 3'h1
`define UFLC_PMODE_DTRDSR 3'h2
`define UFLC_PMODE_485A 3'h3
`define UFLC_PMODE_485B 3'h4
`define UFLC_POL_BIT 3

`define UFLC_FMODE_HW 3'h1
`define UFLC_FMODE_SW 3'h2
`define UFLC_FMODE_MD3 3'h3
`define UFLC_FMODE_MD4 3'h4
`define UFLC_HDX_BIT 3

`define UFLC_RX_HIGH 9'h170
`define UFLC_RX_LOW 9'h100

`define UFLC_CLK_KHZ 25000
`define UFLC_SUSP_MS 3
`define UFLC_GUARD_MS 5
`define UFLC_CNT_W 17

`endif

// ---- uflc_pkg.sv ----
/*
 * Types of the flow and line control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uflc_pkg;
  typedef enum logic [1:0] {
    UFLC_DIR_IDLE = 2'h0,
    UFLC_DIR_ON = 2'h1,
    UFLC_DIR_HOLD = 2'h3
  } uflc_dir_state_type;

  typedef enum logic [1:0] {
    UFLC_SUS_ACTIVE = 2'h0,
    UFLC_SUS_GUARD = 2'h1,
    UFLC_SUS_ASLEEP = 2'h3
  } uflc_sus_state_type;
endpackage : uflc_pkg

// ---- uflc_dir_delay.sv ----
/*
 * RS-485 direction hold: active while transmit work is pending, then held
 * for the programmed number of bit times.
 * Assumes bit_tick pulses once per bit time from the baud generator.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uflc_cfg.svh"

module uflc_dir_delay (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic tx_work,
  input wire logic bit_tick,
  input wire logic [3:0] turnaround_delay,
  output logic dir_active
);
  uflc_pkg::uflc_dir_state_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      uflc_pkg::UFLC_DIR_IDLE: begin
        if (enable && tx_work) begin
          state_nxt = uflc_pkg::UFLC_DIR_ON;
        end
      end
      uflc_pkg::UFLC_DIR_ON: begin
        if (!enable) begin
          state_nxt = uflc_pkg::UFLC_DIR_IDLE;
        end else if (!tx_work) begin
          // zero delay drops right after the last stop bit
          state_nxt = (turnaround_delay == 4'h0) ? uflc_pkg::UFLC_DIR_IDLE
                                                 : uflc_pkg::UFLC_DIR_HOLD;
          cnt_nxt = turnaround_delay;
        end
      end
      uflc_pkg::UFLC_DIR_HOLD: begin
        if (!enable) begin
          state_nxt = uflc_pkg::UFLC_DIR_IDLE;
        end else if (tx_work) begin
          state_nxt = uflc_pkg::UFLC_DIR_ON;
        end else if (bit_tick) begin
          cnt_nxt = cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            state_nxt = uflc_pkg::UFLC_DIR_IDLE;
          end
        end
      end
      default: state_nxt = uflc_pkg::UFLC_DIR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= uflc_pkg::UFLC_DIR_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign dir_active = (state_r != uflc_pkg::UFLC_DIR_IDLE);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  dir_zero_delay_a: assert property (
    (state_r == uflc_pkg::UFLC_DIR_ON) && enable && !tx_work && (turnaround_delay == 4'h0)
    |=> !dir_active) else $error("direction not dropped after last stop bit");
endmodule : uflc_dir_delay

`default_nettype wire

// ---- uflc_suspend.sv ----
/*
 * Bus idle detection into suspend, wakeup guard time, remote wakeup pulse.
 * Assumes usb_activity pulses on any bus traffic including frame starts.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uflc_cfg.svh"

module uflc_suspend #(
  parameter int SUSP_CYC = `UFLC_SUSP_MS * `UFLC_CLK_KHZ,
  parameter int GUARD_CYC = `UFLC_GUARD_MS * `UFLC_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic usb_activity,
  input wire logic wake_allowed,
  input wire logic wakeup_input_pin,
  output logic suspended,
  output logic wakeup_req
);
  uflc_pkg::uflc_sus_state_type state_r, state_nxt;
  logic [`UFLC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic pin_prev_r, wake_r, wake_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + `UFLC_CNT_W'(1);
    wake_nxt = 1'b0;
    if (usb_activity) begin
      state_nxt = uflc_pkg::UFLC_SUS_ACTIVE;
      cnt_nxt = '0;
    end else begin
      unique case (state_r)
        uflc_pkg::UFLC_SUS_ACTIVE: begin
          if (cnt_r >= `UFLC_CNT_W'(SUSP_CYC - 1)) begin
            state_nxt = uflc_pkg::UFLC_SUS_GUARD;
            cnt_nxt = '0;
          end
        end
        uflc_pkg::UFLC_SUS_GUARD: begin
          if (cnt_r >= `UFLC_CNT_W'(GUARD_CYC - 1)) begin
            state_nxt = uflc_pkg::UFLC_SUS_ASLEEP;
          end
        end
        uflc_pkg::UFLC_SUS_ASLEEP: begin
          cnt_nxt = cnt_r;
          wake_nxt = wake_allowed && pin_prev_r && !wakeup_input_pin;
        end
        default: state_nxt = uflc_pkg::UFLC_SUS_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= uflc_pkg::UFLC_SUS_ACTIVE;
      cnt_r <= '0;
      pin_prev_r <= 1'b1;
      wake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pin_prev_r <= wakeup_input_pin;
      wake_r <= wake_nxt;
    end
  end

  assign suspended = (state_r != uflc_pkg::UFLC_SUS_ACTIVE);
  assign wakeup_req = wake_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  wake_guard_a: assert property (
    wakeup_req |-> $past(state_r) == uflc_pkg::UFLC_SUS_ASLEEP)
    else $error("wakeup raised inside guard time");
  wake_gate_a: assert property (
    wakeup_req |-> $past(wake_allowed)) else $error("wakeup raised while not allowed");
endmodule : uflc_suspend

`default_nettype wire

// ---- uflc_line_ctrl.sv ----
/*
 * Line control of a USB UART: general-purpose pins, hardware and software
 * flow control, RS-485 direction, multidrop address match, half duplex,
 * suspend and remote wakeup.
 * Assumes an external shifter reports tx_pending/tx_busy and received
 * characters, and that configuration ports are held by the host side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uflc_cfg.svh"

// Summary of operation
// - six general pins, all inputs after reset until reprogrammed
// - pin mode 001: pin 5 is request output, pin 4 clear input
// - request drops when receive space runs low, returns when freed
// - clear input high (low-active) holds the transmitter
// - pin mode 010 with flow 001: pin 3 ready output, pin 2 ready input
// - flow mode 010 compares each received character with resume and halt
// - halt character stops transmission after the current character
// - resume character restarts transmission after a halt
// - pin modes 3 and 4 make pin 5 the RS-485 direction output
// - direction asserted before the start bit, dropped after the last stop
// - pin mode bit 3 inverts the direction output
// - direction drop delayed by 0 to 15 bit times
// - flow modes 3 and 4: resume holds unicast, halt holds multicast
// - ninth bit set marks an address; match on either address
// - matched address byte is dropped, following data bytes stored
// - unmatched address byte disables the receiver
// - mode 3 sends freely, mode 4 only after an address match
// - flow mode bit 3 ignores receive data while transmitting
// - 3 ms without bus activity starts suspend
// - falling wakeup pin while suspended requests remote wakeup
// - wakeup needs input pin, advertised support and host enable
// - no wakeup in the first 5 ms of suspend
module uflc_line_ctrl #(
  parameter int SUSP_CYC = `UFLC_SUSP_MS * `UFLC_CLK_KHZ,
  parameter int GUARD_CYC = `UFLC_GUARD_MS * `UFLC_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] pin_mode,
  input wire logic [3:0] flow_mode,
  input wire logic [5:0] gpio_dir,
  input wire logic [5:0] gpio_wr,
  input wire logic [7:0] resume_char,
  input wire logic [7:0] halt_char,
  input wire logic [3:0] turnaround_delay,
  input wire logic [5:0] gpio_in,
  output logic [5:0] gpio_out,
  output logic [5:0] gpio_oe_n,
  output logic [5:0] gpio_rd,
  input wire logic tx_pending,
  input wire logic tx_busy,
  input wire logic bit_tick,
  output logic tx_enable,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_bit9,
  input wire logic [8:0] rx_level,
  output logic rx_write,
  output logic [7:0] rx_write_data,
  output logic rx_enabled,
  output logic tx_halted,
  input wire logic usb_activity,
  input wire logic wake_attr,
  input wire logic wake_host_en,
  output logic suspended,
  output logic wakeup_req
);
  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b);
    char_eq = (a == b);
  endfunction : char_eq

  logic hw_rtscts, hw_dtrdsr, rs485_on, pol_inv;
  logic sw_flow, md_mode, md_mode4, hdx;

  assign hw_rtscts = (pin_mode[2:0] == `UFLC_PMODE_RTSCTS);
  assign hw_dtrdsr = (pin_mode[2:0] == `UFLC_PMODE_DTRDSR)
                     && (flow_mode[2:0] == `UFLC_FMODE_HW);
  assign rs485_on = (pin_mode[2:0] == `UFLC_PMODE_485A)
                    || (pin_mode[2:0] == `UFLC_PMODE_485B);
  assign pol_inv = pin_mode[`UFLC_POL_BIT];
  assign sw_flow = (flow_mode[2:0] == `UFLC_FMODE_SW);
  assign md_mode4 = (flow_mode[2:0] == `UFLC_FMODE_MD4);
  assign md_mode = (flow_mode[2:0] == `UFLC_FMODE_MD3) || md_mode4;
  assign hdx = flow_mode[`UFLC_HDX_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // receive acceptance, software flow and address matching

  logic rx_take, addr_hit;
  logic halted_r, halted_nxt;
  logic matched_r, matched_nxt;
  logic rx_en_r, rx_en_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] data_r, data_nxt;

  assign rx_take = rx_char_valid && !(hdx && tx_busy);
  assign addr_hit = char_eq(rx_char, resume_char) || char_eq(rx_char, halt_char);

  always_comb begin
    halted_nxt = halted_r;
    matched_nxt = matched_r;
    rx_en_nxt = rx_en_r;
    wr_nxt = 1'b0;
    data_nxt = data_r;
    if (!sw_flow) begin
      halted_nxt = 1'b0;
    end
    if (!md_mode) begin
      matched_nxt = 1'b0;
      rx_en_nxt = 1'b1;
    end
    if (rx_take) begin
      if (md_mode && rx_bit9) begin
        matched_nxt = addr_hit;
        rx_en_nxt = addr_hit;
      end else if (sw_flow && char_eq(rx_char, halt_char)) begin
        halted_nxt = 1'b1;
      end else if (sw_flow && char_eq(rx_char, resume_char)) begin
        halted_nxt = 1'b0;
      end else if (rx_en_r || !md_mode) begin
        wr_nxt = 1'b1;
        data_nxt = rx_char;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halted_r <= 1'b0;
      matched_r <= 1'b0;
      rx_en_r <= 1'b1;
      wr_r <= 1'b0;
      data_r <= 8'h00;
    end else begin
      halted_r <= halted_nxt;
      matched_r <= matched_nxt;
      rx_en_r <= rx_en_nxt;
      wr_r <= wr_nxt;
      data_r <= data_nxt;
    end
  end

  assign rx_write = wr_r;
  assign rx_write_data = data_r;
  assign rx_enabled = rx_en_r;
  assign tx_halted = halted_r;

  ////////////////////////////////////////////////////////////////////////////
  // receive space hysteresis for the request output

  logic room_r, room_nxt;

  always_comb begin
    room_nxt = room_r;
    if (rx_level >= `UFLC_RX_HIGH) begin
      room_nxt = 1'b0;
    end else if (rx_level < `UFLC_RX_LOW) begin
      room_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      room_r <= 1'b1;
    end else begin
      room_r <= room_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit permission and RS-485 direction

  logic dir_active, remote_ready;

  uflc_dir_delay u_dir (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(rs485_on),
    .tx_work(tx_pending || tx_busy),
    .bit_tick(bit_tick),
    .turnaround_delay(turnaround_delay),
    .dir_active(dir_active)
  );

  // low-active ready inputs from the far end
  assign remote_ready = hw_rtscts ? !gpio_in[`UFLC_PIN_CTS]
                      : hw_dtrdsr ? !gpio_in[`UFLC_PIN_DSR] : 1'b1;

  // gates only the start of the next character
  assign tx_enable = remote_ready && !halted_r
                     && (!md_mode4 || matched_r)
                     && (!rs485_on || dir_active);

  ////////////////////////////////////////////////////////////////////////////
  // general-purpose pins

  logic [5:0] out_r, out_nxt, oe_n_r, oe_n_nxt;

  always_comb begin
    out_nxt = gpio_wr;
    oe_n_nxt = ~gpio_dir;
    if (hw_rtscts) begin
      out_nxt[`UFLC_PIN_DIR] = !room_nxt;
      oe_n_nxt[`UFLC_PIN_DIR] = 1'b0;
      oe_n_nxt[`UFLC_PIN_CTS] = 1'b1;
    end else if (rs485_on) begin
      out_nxt[`UFLC_PIN_DIR] = dir_active ^ pol_inv;
      oe_n_nxt[`UFLC_PIN_DIR] = 1'b0;
    end
    if (hw_dtrdsr) begin
      out_nxt[`UFLC_PIN_DTR] = !room_nxt;
      oe_n_nxt[`UFLC_PIN_DTR] = 1'b0;
      oe_n_nxt[`UFLC_PIN_DSR] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_r <= 6'h00;
      oe_n_r <= 6'h3F;
    end else begin
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign gpio_out = out_r;
  assign gpio_oe_n = oe_n_r;
  assign gpio_rd = gpio_in;

  ////////////////////////////////////////////////////////////////////////////
  // suspend and remote wakeup

  uflc_suspend #(
    .SUSP_CYC(SUSP_CYC),
    .GUARD_CYC(GUARD_CYC)
  ) u_sus (
    .ref_clk(ref_clk),
    .rst(rst),
    .usb_activity(usb_activity),
    .wake_allowed(oe_n_r[`UFLC_PIN_WAKE] && wake_attr && wake_host_en),
    .wakeup_input_pin(gpio_in[`UFLC_PIN_WAKE]),
    .suspended(suspended),
    .wakeup_req(wakeup_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  rts_full_a: assert property (
    hw_rtscts && (rx_level >= `UFLC_RX_HIGH) |=> gpio_out[`UFLC_PIN_DIR])
    else $error("request not dropped at high level");
  cts_hold_a: assert property (
    hw_rtscts && gpio_in[`UFLC_PIN_CTS] |-> !tx_enable)
    else $error("transmit allowed with clear deasserted");
  halt_char_a: assert property (
    sw_flow && rx_take && char_eq(rx_char, halt_char) ##1 sw_flow |-> !tx_enable)
    else $error("halt character did not stop transmit");
  resume_char_a: assert property (
    sw_flow && rx_take && !char_eq(rx_char, halt_char) && char_eq(rx_char, resume_char)
    |=> !tx_halted) else $error("resume character ignored");
  addr_drop_a: assert property (
    md_mode && rx_take && rx_bit9 |=> !rx_write) else $error("address byte stored");
  addr_miss_a: assert property (
    md_mode && rx_take && rx_bit9 && !addr_hit ##1 md_mode |-> !rx_enabled ##1 !rx_write)
    else $error("receiver left on after address miss");
  mode4_send_a: assert property (
    md_mode4 && !matched_r |-> !tx_enable) else $error("mode 4 sent without match");
  hdx_ignore_a: assert property (
    hdx && tx_busy && rx_char_valid |=> !rx_write) else $error("receive taken in half duplex");
  dir_first_a: assert property (
    rs485_on && tx_enable |-> dir_active) else $error("send without direction asserted");
  dir_pol_a: assert property (
    rs485_on && $stable(pin_mode)
    |=> gpio_out[`UFLC_PIN_DIR] == ($past(dir_active) ^ $past(pol_inv)))
    else $error("direction polarity wrong");
endmodule : uflc_line_ctrl

`default_nettype wire

// ---- uflc_remote_node.sv ----
/* remote serial node: sends received characters, drives handshake pins.
   assumes tasks are called from the ref_clk domain. */
`timescale 1ns/1ps
`default_nettype none

module uflc_remote_node (
  input wire logic ref_clk,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic rx_bit9,
  output logic [5:0] pins
);
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_bit9 = 1'b0;
    pins = 6'h3F;
  end

  // one character per strobe; released lines show the inverse
  task automatic send(input logic [7:0] c, input logic b9);
    @(posedge ref_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    rx_bit9 <= b9;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    rx_bit9 <= ~b9;
  endtask : send

  task automatic set_pin(input int i, input logic v);
    @(posedge ref_clk);
    pins[i] <= v;
  endtask : set_pin
endmodule : uflc_remote_node

`default_nettype wire

// ---- uflc_line_ctrl_tb_top.sv ----
/* self-checking bench of the line control block.
   assumes a 25 MHz clock and shortened suspend and guard counts. */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end

module uflc_line_ctrl_tb_top;
  logic ref_clk, rst, tx_pending, tx_busy, bit_tick;
  logic [3:0] pin_mode, flow_mode, turnaround_delay;
  logic [5:0] gpio_dir, gpio_wr, gpio_in, gpio_out, gpio_oe_n, gpio_rd;
  logic [7:0] resume_char, halt_char, rx_char, rx_write_data;
  logic [8:0] rx_level;
  logic rx_char_valid, rx_bit9, tx_enable, rx_write, rx_enabled, tx_halted;
  logic usb_activity, wake_attr, wake_host_en, suspended, wakeup_req;
  int errors = 0;
  int n_tests = 0;

  uflc_line_ctrl #(.SUSP_CYC(20), .GUARD_CYC(30)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .pin_mode(pin_mode), .flow_mode(flow_mode),
    .gpio_dir(gpio_dir), .gpio_wr(gpio_wr), .resume_char(resume_char),
    .halt_char(halt_char), .turnaround_delay(turnaround_delay), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .gpio_rd(gpio_rd),
    .tx_pending(tx_pending), .tx_busy(tx_busy), .bit_tick(bit_tick),
    .tx_enable(tx_enable), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_bit9(rx_bit9), .rx_level(rx_level), .rx_write(rx_write),
    .rx_write_data(rx_write_data), .rx_enabled(rx_enabled), .tx_halted(tx_halted),
    .usb_activity(usb_activity), .wake_attr(wake_attr), .wake_host_en(wake_host_en),
    .suspended(suspended), .wakeup_req(wakeup_req)
  );

  uflc_remote_node u_peer (
    .ref_clk(ref_clk), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_bit9(rx_bit9), .pins(gpio_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cfg(input logic [3:0] p, input logic [3:0] f);
    @(posedge ref_clk);
    pin_mode <= p;
    flow_mode <= f;
    @(posedge ref_clk);
    #1;
  endtask : cfg

  task automatic lvl(input logic [8:0] v);
    @(posedge ref_clk);
    rx_level <= v;
    @(posedge ref_clk);
    #1;
  endtask : lvl

  task automatic rx(input logic [7:0] c, input logic b9, input logic wr);
    u_peer.send(c, b9);
    #1;
    `CHK("rx_write", rx_write, wr)
    if (wr === 1'b1) `CHK("rx_data", rx_write_data, c)
  endtask : rx

  task automatic watch_wake(output logic seen);
    seen = 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      if (wakeup_req === 1'b1) seen = 1'b1;
    end
  endtask : watch_wake

  ////////////////////////////////////////////////////////////
  task automatic t_gpio();
    @(posedge ref_clk);
    gpio_dir <= 6'h02;
    gpio_wr <= 6'h02;
    @(posedge ref_clk);
    #1;
    `CHK("gpio_oe", gpio_oe_n, 6'h3D)
    `CHK("gpio_out", gpio_out[1], 1'b1)
    `CHK("gpio_rd", gpio_rd, 6'h3F)
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_hw(input logic [3:0] p, input int rq, input int cl);
    cfg(p, 4'h1);
    u_peer.set_pin(cl, 1'b0);
    #1 `CHK("clear_on", tx_enable, 1'b1)
    u_peer.set_pin(cl, 1'b1);
    #1 `CHK("clear_off", tx_enable, 1'b0)
    lvl(9'h170);
    `CHK("req_high", gpio_out[rq], 1'b1)
    `CHK("req_oe", gpio_oe_n[rq], 1'b0)
    lvl(9'h100);
    `CHK("req_hyst", gpio_out[rq], 1'b1)
    lvl(9'h0FF);
    `CHK("req_low", gpio_out[rq], 1'b0)
    u_peer.set_pin(cl, 1'b1 ^ 1'b1);
    $display("test hardware flow done");
  endtask : t_hw

  task automatic t_sw();
    resume_char <= 8'h11;
    halt_char <= 8'h13;
    cfg(4'h0, 4'h2);
    rx(8'h41, 1'b0, 1'b1);
    rx(8'h13, 1'b0, 1'b0);
    `CHK("halted", tx_halted, 1'b1)
    `CHK("halt_tx", tx_enable, 1'b0)
    rx(8'h42, 1'b0, 1'b1);
    rx(8'h11, 1'b0, 1'b0);
    `CHK("resumed", tx_halted, 1'b0)
    `CHK("resume_tx", tx_enable, 1'b1)
    $display("test software flow done");
  endtask : t_sw

  task automatic t_md();
    resume_char <= 8'h21;
    halt_char <= 8'h7E;
    cfg(4'h0, 4'h4);
    `CHK("md4_idle", tx_enable, 1'b0)
    rx(8'h21, 1'b1, 1'b0);
    `CHK("uni_hit", rx_enabled, 1'b1)
    `CHK("md4_tx", tx_enable, 1'b1)
    rx(8'h55, 1'b0, 1'b1);
    rx(8'h33, 1'b1, 1'b0);
    `CHK("miss", rx_enabled, 1'b0)
    rx(8'h56, 1'b0, 1'b0);
    rx(8'h7E, 1'b1, 1'b0);
    `CHK("multi_hit", rx_enabled, 1'b1)
    cfg(4'h0, 4'h0);
    cfg(4'h0, 4'h3);
    `CHK("md3_tx", tx_enable, 1'b1)
    $display("test multidrop done");
  endtask : t_md

  task automatic t_hdx();
    cfg(4'h0, 4'h8);
    @(posedge ref_clk);
    tx_busy <= 1'b1;
    rx(8'h44, 1'b0, 1'b0);
    @(posedge ref_clk);
    tx_busy <= 1'b0;
    rx(8'h45, 1'b0, 1'b1);
    $display("test half duplex done");
  endtask : t_hdx

  task automatic t_485(input logic [2:0] m, input logic inv, input logic [3:0] d);
    int k;
    @(posedge ref_clk);
    tx_pending <= 1'b0;
    turnaround_delay <= d;
    cfg({inv, m}, 4'h0);
    `CHK("dir_idle", gpio_out[5], inv)
    @(posedge ref_clk);
    tx_pending <= 1'b1;
    #1 `CHK("tx_lead", tx_enable, 1'b0)
    @(posedge ref_clk);
    #1 `CHK("tx_go", tx_enable, 1'b1)
    @(posedge ref_clk);
    #1 `CHK("dir_on", gpio_out[5], ~inv)
    `CHK("dir_oe", gpio_oe_n[5], 1'b0)
    @(posedge ref_clk);
    tx_pending <= 1'b0;
    @(posedge ref_clk);
    #1 `CHK("dir_hold", gpio_out[5], ~inv)
    for (k = 0; k < d; k++) begin
      repeat (2) @(posedge ref_clk);
      bit_tick <= 1'b1;
      @(posedge ref_clk);
      bit_tick <= 1'b0;
      #1 `CHK("dir_hold", gpio_out[5], ~inv)
    end
    @(posedge ref_clk);
    #1 `CHK("dir_drop", gpio_out[5], inv)
    $display("test direction done");
  endtask : t_485

  task automatic t_susp();
    int i;
    logic seen;
    @(posedge ref_clk);
    usb_activity <= 1'b0;
    repeat (15) @(posedge ref_clk);
    #1 `CHK("susp_early", suspended, 1'b0)
    for (i = 0; i < 12 && suspended !== 1'b1; i++) @(posedge ref_clk);
    #1 `CHK("susp", suspended, 1'b1)
    if (suspended !== 1'b1) tally_and_finish();
    u_peer.set_pin(0, 1'b0);
    watch_wake(seen);
    `CHK("guard_wake", seen, 1'b0)
    u_peer.set_pin(0, 1'b1);
    repeat (35) @(posedge ref_clk);
    wake_host_en <= 1'b0;
    u_peer.set_pin(0, 1'b0);
    watch_wake(seen);
    `CHK("wake_off", seen, 1'b0)
    u_peer.set_pin(0, 1'b1);
    @(posedge ref_clk);
    wake_host_en <= 1'b1;
    wake_attr <= 1'b0;
    u_peer.set_pin(0, 1'b0);
    watch_wake(seen);
    `CHK("wake_attr", seen, 1'b0)
    u_peer.set_pin(0, 1'b1);
    @(posedge ref_clk);
    wake_attr <= 1'b1;
    u_peer.set_pin(0, 1'b0);
    watch_wake(seen);
    `CHK("wake_req", seen, 1'b1)
    @(posedge ref_clk);
    usb_activity <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("resume", suspended, 1'b0)
    $display("test suspend done");
  endtask : t_susp

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("BAD watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    pin_mode = 4'h0;
    flow_mode = 4'h0;
    gpio_dir = 6'h00;
    gpio_wr = 6'h00;
    resume_char = 8'h11;
    halt_char = 8'h13;
    turnaround_delay = 4'h0;
    tx_pending = 1'b1;
    tx_busy = 1'b0;
    bit_tick = 1'b0;
    rx_level = 9'h000;
    usb_activity = 1'b1;
    wake_attr = 1'b1;
    wake_host_en = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 `CHK("oe_rst", gpio_oe_n, 6'h3F)
    `CHK("out_rst", gpio_out, 6'h00)
    `CHK("rxen_rst", rx_enabled, 1'b1)
    `CHK("halt_rst", tx_halted, 1'b0)
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_gpio();
    t_hw(4'h1, 5, 4);
    t_hw(4'h2, 3, 2);
    t_sw();
    t_md();
    t_hdx();
    t_485(3'h3, 1'b0, 4'h0);
    t_485(3'h4, 1'b1, 4'h2);
    t_485(3'h3, 1'b1, 4'hF);
    t_susp();
    tally_and_finish();
  end
endmodule : uflc_line_ctrl_tb_top

`default_nettype wire
